// ### verilog/asu_pkg.sv
package asu_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_DATA = 12'h000;
  localparam logic [11:0] OFS_RSR  = 12'h004;
  localparam logic [11:0] OFS_FLAG = 12'h018;
  localparam logic [11:0] OFS_IBRD = 12'h024;
  localparam logic [11:0] OFS_FBRD = 12'h028;
  localparam logic [11:0] OFS_LCR  = 12'h02c;
  localparam logic [11:0] OFS_CTL  = 12'h030;
  localparam logic [11:0] OFS_IFLS = 12'h034;
  localparam logic [11:0] OFS_IM   = 12'h038;
  localparam logic [11:0] OFS_RIS  = 12'h03c;
  localparam logic [11:0] OFS_MIS  = 12'h040;
  localparam logic [11:0] OFS_ICR  = 12'h044;

  // reset values
  localparam logic [9:0] CTL_RST  = 10'h300;
  localparam logic [5:0] IFLS_RST = 6'h12;

  // control bit positions
  localparam int CTL_EN_BIT  = 0;
  localparam int CTL_LBK_BIT = 7;
  localparam int CTL_TXE_BIT = 8;
  localparam int CTL_RXE_BIT = 9;

  // event vector: bit index, shifted up by EV_SHIFT in the registers
  localparam int EV_SHIFT = 4;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_RT = 2;
  localparam int EV_FE = 3;
  localparam int EV_PE = 4;
  localparam int EV_BK = 5;
  localparam int EV_OE = 6;
  localparam int EV_W  = 7;

  // flag register bit positions
  localparam int FLG_BUSY = 3;
  localparam int FLG_RX_EMPTY_FLAG = 4;
  localparam int FLG_TX_FULL_FLAG = 5;
  localparam int FLG_RX_FULL_FLAG = 6;
  localparam int FLG_TX_EMPTY_FLAG = 7;

  // timing
  localparam int          FIFO_DEPTH = 16;
  localparam logic [3:0]  OVS_LAST   = 4'hf;
  localparam logic [3:0]  START_SMP  = 4'h7;
  localparam logic [5:0]  RT_BITS    = 6'h20;
  localparam logic [22:0] FRAC_ONE   = 23'h000040;

  typedef struct packed {
    logic       stick;
    logic [1:0] wlen;
    logic       fifo_enable_bit;
    logic       two_stop;
    logic       even;
    logic       par_en;
    logic       brk;
  } asu_lcr_t;

  typedef struct packed {
    logic [15:0] ibrd;
    logic [5:0]  fbrd;
    asu_lcr_t    lcr;
  } asu_work_t;

  typedef struct packed {
    logic       overrun_err;
    logic       break_flag;
    logic       parity_err;
    logic       frame_err;
    logic [7:0] data;
  } asu_rx_entry_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } asu_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRK   = 3'b101
  } asu_rx_state_t;

  function automatic logic [4:0] asu_level(input logic [2:0] sel);
    unique case (sel)
      3'h0:    asu_level = 5'h02;
      3'h1:    asu_level = 5'h04;
      3'h3:    asu_level = 5'h0c;
      3'h4:    asu_level = 5'h0e;
      default: asu_level = 5'h08;
    endcase
  endfunction

  function automatic logic [7:0] asu_mask(input logic [7:0] d, input logic [1:0] wlen);
    asu_mask = d & (8'hff >> (2'h3 - wlen));
  endfunction

  function automatic logic asu_parity(input logic [7:0] d, input asu_lcr_t l);
    asu_parity = l.stick ? ~l.even : ((^asu_mask(d, l.wlen)) ^ ~l.even);
  endfunction

endpackage

// ### verilog/asu_fifo.sv
module asu_fifo #(
  parameter int W = 12
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic         deep_in,
  input  wire logic         push_in,
  input  wire logic [W-1:0] data_in,
  input  wire logic         pop_in,
  output logic [W-1:0]      data_out,
  output logic [4:0]        count_out,
  output logic              full_out,
  output logic              empty_out
);
  import asu_pkg::*;

  logic [W-1:0] mem [FIFO_DEPTH];
  logic [3:0]   rd_ptr_reg;
  logic [3:0]   wr_ptr_reg;
  logic [4:0]   count_reg;
  logic         do_push;
  logic         do_pop;

  // shallow mode behaves as a single holding register
  assign full_out  = deep_in ? (count_reg == 5'h10) : (count_reg != 5'h00);
  assign empty_out = (count_reg == 5'h00);
  assign count_out = count_reg;
  assign data_out  = mem[rd_ptr_reg];
  assign do_push   = push_in && !full_out;
  assign do_pop    = pop_in && !empty_out;

  always_ff @(posedge clk_in) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_ptr_reg <= 4'h0;
      wr_ptr_reg <= 4'h0;
      count_reg  <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 4'h1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 4'h1;
      end
      count_reg <= count_reg + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

endmodule

// ### verilog/asu_uart.sv
module asu_uart (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        serial_in_in,
  output logic             serial_out_out,
  output logic             irq_out
);
  import asu_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  logic [9:0]      control_reg;
  logic [15:0]     divisor_integer_reg;
  logic [5:0]      divisor_fraction_reg;
  asu_work_t       work_reg;
  logic [5:0]      fifo_level_select_reg;
  logic [EV_W-1:0] event_mask_reg;
  logic [EV_W-1:0] raw_event_reg;
  logic [3:0]      rx_status_reg;
  logic            wait_reg;
  logic [31:0]     rdata_reg;
  logic            irq_reg;
  logic            serial_out_reg;
  logic [22:0]     baud_acc_reg;
  logic            tick_reg;

  asu_tx_state_t   tx_state_reg;
  logic [3:0]      tx_cnt_reg;
  logic [2:0]      tx_bit_reg;
  logic [7:0]      tx_shift_reg;
  logic            tx_par_reg;
  logic            tx_line_reg;

  asu_rx_state_t   rx_state_reg;
  logic [3:0]      rx_cnt_reg;
  logic [2:0]      rx_bit_reg;
  logic [7:0]      rx_shift_reg;
  logic            rx_pe_reg;
  logic            rx_parline_reg;
  logic            oe_pend_reg;
  logic [3:0]      rt_cnt_reg;
  logic [5:0]      rt_bits_reg;

  logic            accept;
  logic            wr_acc;
  logic            rd_acc;
  logic            global_enable_bit;
  logic            tx_enable_bit;
  logic            rx_enable_bit;
  logic            loopback_bit;
  asu_lcr_t        lcr;
  logic [22:0]     divisor;
  logic [22:0]     acc_sum;
  logic            tx_push;
  logic            tx_pop;
  logic [7:0]      tx_head;
  logic [4:0]      tx_count;
  logic            tx_full_flag;
  logic            tx_empty_flag;
  logic            rx_push;
  logic            rx_pop;
  asu_rx_entry_t   rx_entry;
  asu_rx_entry_t   rx_head;
  logic [4:0]      rx_count;
  logic            rx_full_flag;
  logic            rx_empty_flag;
  logic            line_rx;
  logic            stop_done;
  logic            rt_hit;
  logic            busy;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic [2:0]      last_bit;
  logic [4:0]      rx_level;
  logic [4:0]      tx_level;

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave: request seen with waitrequest high, answered next cycle
  assign accept = (avs_read_in || avs_write_in) && wait_reg;
  assign wr_acc = accept && avs_write_in;
  assign rd_acc = accept && avs_read_in;

  assign global_enable_bit = control_reg[CTL_EN_BIT];
  assign loopback_bit      = control_reg[CTL_LBK_BIT];
  assign tx_enable_bit     = control_reg[CTL_TXE_BIT];
  assign rx_enable_bit     = control_reg[CTL_RXE_BIT];
  assign lcr               = work_reg.lcr;
  assign last_bit          = {1'b1, lcr.wlen};

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !accept;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control_reg           <= CTL_RST;
      divisor_integer_reg   <= 16'h0000;
      divisor_fraction_reg  <= 6'h00;
      work_reg              <= '0;
      fifo_level_select_reg <= IFLS_RST;
      event_mask_reg        <= '0;
    end else if (wr_acc) begin
      unique case (avs_address_in)
        OFS_CTL:  control_reg <= avs_writedata_in[9:0];
        OFS_IBRD: divisor_integer_reg <= avs_writedata_in[15:0];
        OFS_FBRD: divisor_fraction_reg <= avs_writedata_in[5:0];
        OFS_LCR:  work_reg <= {divisor_integer_reg, divisor_fraction_reg,
                               avs_writedata_in[7:0]};
        OFS_IFLS: fifo_level_select_reg <= avs_writedata_in[5:0];
        OFS_IM:   event_mask_reg <= avs_writedata_in[EV_SHIFT +: EV_W];
        default:  ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_reg <= 32'h00000000;
    end else if (rd_acc) begin
      unique case (avs_address_in)
        OFS_DATA: rdata_reg <= {20'h00000, rx_head};
        OFS_RSR:  rdata_reg <= {28'h0000000, rx_status_reg};
        OFS_FLAG: begin
          rdata_reg           <= 32'h00000000;
          rdata_reg[FLG_BUSY] <= busy;
          rdata_reg[FLG_RX_EMPTY_FLAG] <= rx_empty_flag;
          rdata_reg[FLG_TX_FULL_FLAG] <= tx_full_flag;
          rdata_reg[FLG_RX_FULL_FLAG] <= rx_full_flag;
          rdata_reg[FLG_TX_EMPTY_FLAG] <= tx_empty_flag;
        end
        OFS_IBRD: rdata_reg <= {16'h0000, divisor_integer_reg};
        OFS_FBRD: rdata_reg <= {26'h0000000, divisor_fraction_reg};
        OFS_LCR:  rdata_reg <= {24'h000000, lcr};
        OFS_CTL:  rdata_reg <= {22'h000000, control_reg};
        OFS_IFLS: rdata_reg <= {26'h0000000, fifo_level_select_reg};
        OFS_IM:   rdata_reg <= {21'h000000, event_mask_reg, 4'h0};
        OFS_RIS:  rdata_reg <= {21'h000000, raw_event_reg, 4'h0};
        OFS_MIS:  rdata_reg <= {21'h000000, raw_event_reg & event_mask_reg, 4'h0};
        default:  rdata_reg <= 32'h00000000;
      endcase
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = wait_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // fractional baud generator in 1/64 units; divisor below 1.0 halts it
  assign divisor = {1'b0, work_reg.ibrd, work_reg.fbrd};
  assign acc_sum = baud_acc_reg + FRAC_ONE;

  always_ff @(posedge clk_in) begin
    if (rst_in || work_reg.ibrd == 16'h0000) begin
      baud_acc_reg <= 23'h000000;
      tick_reg     <= 1'b0;
    end else if (acc_sum >= divisor) begin
      baud_acc_reg <= acc_sum - divisor;
      tick_reg     <= 1'b1;
    end else begin
      baud_acc_reg <= acc_sum;
      tick_reg     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // fifos
  assign tx_push = wr_acc && avs_address_in == OFS_DATA;
  assign rx_pop  = rd_acc && avs_address_in == OFS_DATA;

  asu_fifo #(.W(8)) u_tx_fifo (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .deep_in   (lcr.fifo_enable_bit),
    .push_in   (tx_push),
    .data_in   (avs_writedata_in[7:0]),
    .pop_in    (tx_pop),
    .data_out  (tx_head),
    .count_out (tx_count),
    .full_out  (tx_full_flag),
    .empty_out (tx_empty_flag)
  );

  asu_fifo #(.W(12)) u_rx_fifo (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .deep_in   (lcr.fifo_enable_bit),
    .push_in   (rx_push),
    .data_in   (rx_entry),
    .pop_in    (rx_pop),
    .data_out  (rx_head),
    .count_out (rx_count),
    .full_out  (rx_full_flag),
    .empty_out (rx_empty_flag)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter; a new character starts only while enabled
  assign tx_pop = tick_reg && tx_state_reg == TX_IDLE && !tx_empty_flag
                  && global_enable_bit && tx_enable_bit;
  assign busy   = !tx_empty_flag || tx_state_reg != TX_IDLE;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg   <= 1'b0;
      tx_line_reg  <= 1'b1;
    end else if (tx_pop) begin
      tx_state_reg <= TX_START;
      tx_cnt_reg   <= 4'h0;
      tx_shift_reg <= tx_head;
      tx_par_reg   <= asu_parity(tx_head, lcr);
      tx_line_reg  <= 1'b0;
    end else if (tick_reg && tx_state_reg != TX_IDLE) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (tx_cnt_reg == OVS_LAST) begin
        unique case (tx_state_reg)
          TX_START: begin
            tx_state_reg <= TX_DATA;
            tx_bit_reg   <= 3'h0;
            tx_line_reg  <= tx_shift_reg[0];
          end
          TX_DATA: begin
            if (tx_bit_reg == last_bit) begin
              tx_state_reg <= lcr.par_en ? TX_PAR : TX_STOP;
              tx_line_reg  <= lcr.par_en ? tx_par_reg : 1'b1;
              tx_bit_reg   <= 3'h0;
            end else begin
              tx_bit_reg   <= tx_bit_reg + 3'h1;
              tx_shift_reg <= tx_shift_reg >> 1;
              tx_line_reg  <= tx_shift_reg[1];
            end
          end
          TX_PAR: begin
            tx_state_reg <= TX_STOP;
            tx_line_reg  <= 1'b1;
          end
          TX_STOP: begin
            if (lcr.two_stop && tx_bit_reg == 3'h0) begin
              tx_bit_reg <= 3'h1;
            end else begin
              tx_state_reg <= TX_IDLE;
            end
          end
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // break send forces the line low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      serial_out_reg <= 1'b1;
    end else begin
      serial_out_reg <= tx_line_reg && !lcr.brk;
    end
  end

  assign serial_out_out = serial_out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // receiver
  assign line_rx   = loopback_bit ? serial_out_reg : serial_in_in;
  assign stop_done = tick_reg && rx_state_reg == RX_STOP && rx_cnt_reg == OVS_LAST;
  assign rx_push   = stop_done && !rx_full_flag;

  always_comb begin
    rx_entry             = '0;
    rx_entry.data        = rx_shift_reg;
    rx_entry.parity_err  = rx_pe_reg;
    rx_entry.frame_err   = !line_rx;
    rx_entry.break_flag  = !line_rx && rx_shift_reg == 8'h00
                           && !rx_parline_reg;
    rx_entry.overrun_err = oe_pend_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_state_reg   <= RX_IDLE;
      rx_cnt_reg     <= 4'h0;
      rx_bit_reg     <= 3'h0;
      rx_shift_reg   <= 8'h00;
      rx_pe_reg      <= 1'b0;
      rx_parline_reg <= 1'b0;
    end else if (tick_reg) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 4'h0;
          if (!line_rx && global_enable_bit && rx_enable_bit) begin
            rx_state_reg   <= RX_START;
            rx_shift_reg   <= 8'h00;
            rx_pe_reg      <= 1'b0;
            rx_parline_reg <= 1'b0;
          end
        end
        RX_START: begin
          if (rx_cnt_reg == START_SMP) begin
            rx_state_reg <= line_rx ? RX_IDLE : RX_DATA;
            rx_cnt_reg   <= 4'h0;
            rx_bit_reg   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_cnt_reg == OVS_LAST) begin
            rx_shift_reg[rx_bit_reg] <= line_rx;
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit) begin
              rx_state_reg <= lcr.par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_cnt_reg == OVS_LAST) begin
            rx_parline_reg <= line_rx;
            rx_pe_reg      <= line_rx != asu_parity(rx_shift_reg, lcr);
            rx_state_reg   <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_cnt_reg == OVS_LAST) begin
            rx_state_reg <= rx_entry.break_flag ? RX_BRK : RX_IDLE;
          end
        end
        RX_BRK: begin
          rx_cnt_reg <= 4'h0;
          if (line_rx) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // lost character tags the next stored one
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      oe_pend_reg <= 1'b0;
    end else if (stop_done) begin
      oe_pend_reg <= rx_full_flag;
    end
  end

  // status of the last character read; write clears, overrun set wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_status_reg <= 4'h0;
    end else begin
      if (wr_acc && avs_address_in == OFS_RSR) begin
        rx_status_reg <= 4'h0;
      end else if (rx_pop && !rx_empty_flag) begin
        rx_status_reg <= rx_head[11:8];
      end
      if (stop_done && rx_full_flag) begin
        rx_status_reg[3] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive timeout in whole bit periods
  assign rt_hit = tick_reg && rt_cnt_reg == OVS_LAST && rt_bits_reg == RT_BITS - 6'h01;

  always_ff @(posedge clk_in) begin
    if (rst_in || rx_push || rx_empty_flag) begin
      rt_cnt_reg  <= 4'h0;
      rt_bits_reg <= 6'h00;
    end else if (tick_reg && rt_bits_reg != RT_BITS) begin
      rt_cnt_reg <= rt_cnt_reg + 4'h1;
      if (rt_cnt_reg == OVS_LAST) begin
        rt_bits_reg <= rt_bits_reg + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // events: sticky, set wins over clear
  assign rx_level = lcr.fifo_enable_bit ? asu_level(fifo_level_select_reg[5:3]) : 5'h01;
  assign tx_level = lcr.fifo_enable_bit ? asu_level(fifo_level_select_reg[2:0]) : 5'h00;

  always_comb begin
    ev_set        = '0;
    ev_set[EV_RX] = rx_count >= rx_level;
    ev_set[EV_TX] = tx_count <= tx_level;
    ev_set[EV_RT] = rt_hit;
    ev_set[EV_FE] = rx_push && rx_entry.frame_err;
    ev_set[EV_PE] = rx_push && rx_entry.parity_err;
    ev_set[EV_BK] = rx_push && rx_entry.break_flag;
    ev_set[EV_OE] = stop_done && rx_full_flag;
    ev_clr        = wr_acc && avs_address_in == OFS_ICR
                    ? avs_writedata_in[EV_SHIFT +: EV_W] : '0;
    ev_clr[EV_RT] = ev_clr[EV_RT] || rx_empty_flag;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      raw_event_reg <= '0;
    end else begin
      raw_event_reg <= (raw_event_reg & ~ev_clr) | ev_set;
    end
  end

  // one request line, one cycle behind the masked status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(raw_event_reg & event_mask_reg);
    end
  end

  assign irq_out = irq_reg;

endmodule

// ### testbench/asu_uart_props.sv
module asu_uart_props
  import asu_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [11:0] avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        serial_in_in,
  input wire logic        serial_out_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] low_cnt;
  logic [4:0] high_cnt;
  wire        taken = (avs_read_in || avs_write_in) && avs_waitrequest_out;
  ////////////////////////////////////////////////////////////////
  // run lengths of the line, saturating
  always_ff @(posedge clk_in) begin
    if (rst_in || serial_out_out) low_cnt <= 5'h00;
    else if (low_cnt != 5'h1f) low_cnt <= low_cnt + 5'h01;
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) high_cnt <= 5'h1f;
    else if (!serial_out_out) high_cnt <= 5'h00;
    else if (high_cnt != 5'h1f) high_cnt <= high_cnt + 5'h01;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  AST_ANSWER_NEXT: assert property (taken |=> !avs_waitrequest_out)
    else $error("no answer one cycle after request");
  AST_ANSWER_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer held more than one cycle");
  AST_NO_SPURIOUS: assert property (
    !avs_read_in && !avs_write_in && avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer without request");
  AST_UNMAPPED_ZERO: assert property (
    avs_read_in && avs_waitrequest_out && avs_address_in == 12'h008
    |=> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_READ_HOLDS: assert property (
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data moved without read");
  AST_START_LEN: assert property ($rose(serial_out_out) |-> low_cnt >= 5'h10)
    else $error("low pulse shorter than one bit");
  AST_IDLE_LEN: assert property ($fell(serial_out_out) |-> high_cnt >= 5'h10)
    else $error("start bit without full stop before");
  AST_MASK_OFF: assert property (
    avs_write_in && avs_waitrequest_out && avs_address_in == OFS_IM &&
    avs_writedata_in == 32'h0 |=> ##1 !irq_out)
    else $error("irq with all events masked");
  cover property ($fell(serial_out_out));
  cover property ($rose(irq_out));
  cover property (avs_read_in && !avs_waitrequest_out);
endmodule

// ### testbench/asu_remote.sv
module asu_remote (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT_CLKS = 16;
  logic [7:0] got_q[$];
  logic [7:0] shf;
  initial line_out = 1'b1;
  ////////////////////////////////////////////////////////////////
  // start, data lsb first, one stop
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= fr[i];
      repeat (BIT_CLKS) @(posedge clk_in);
    end
  endtask
  task automatic hold_low(input int n);
    line_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////////
  // mid-bit sampling of the device line
  always begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(posedge clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_in);
      shf[i] = line_in;
    end
    got_q.push_back(shf);
    repeat (BIT_CLKS) @(posedge clk_in);
  end
endmodule

// ### testbench/testbench.sv
bind asu_uart asu_uart_props chk_u (.clk_in(clk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .serial_in_in(serial_in_in),
  .serial_out_out(serial_out_out), .irq_out(irq_out));
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import asu_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [11:0] addr   = 12'h0;
  logic        rd     = 1'b0;
  logic        wr     = 1'b0;
  logic [31:0] wdata  = 32'h0;
  logic [31:0] rdata;
  logic        waitr;
  logic        ser_in;
  logic        ser_out;
  logic        irq;
  logic [31:0] q;
  logic [7:0]  b;
  logic [7:0]  exp_q[$];
  int          errors  = 0;
  int          checked = 0;
  always #25 clk_in = ~clk_in;
  asu_uart dut_u (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitr), .serial_in_in(ser_in), .serial_out_out(ser_out),
    .irq_out(irq));
  asu_remote remote_u (.clk_in(clk_in), .line_in(ser_out), .line_out(ser_in));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // no local limit: only the watchdog ends a wait for the answer
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk_in);
    end while (waitr !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, q & m, e);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    tally_and_finish;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h6235f481));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rdc(OFS_CTL, '1, 32'h300, "ctl");
    rdc(OFS_IFLS, '1, 32'h12, "ifls");
    rdc(OFS_FLAG, 32'hf8, 32'h90, "flag");
    rdc(12'h008, '1, 32'h0, "unmapped");
    xfer(1'b1, OFS_CTL, 32'h300);
    xfer(1'b1, OFS_FBRD, 32'h0);
    xfer(1'b1, OFS_IBRD, 32'h1);
    xfer(1'b1, OFS_LCR, 32'h70);
    xfer(1'b1, OFS_CTL, 32'h301);
    for (int i = 0; i < 4; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      xfer(1'b1, OFS_DATA, {24'h0, b});
    end
    rdc(OFS_FLAG, 32'h08, 32'h08, "busy");
    while (remote_u.got_q.size() < 4) begin
      @(posedge clk_in);
    end
    repeat (40) @(posedge clk_in);
    for (int i = 0; i < 4; i++) chk("tx char", remote_u.got_q[i], exp_q.pop_front());
    rdc(OFS_FLAG, 32'hf8, 32'h90, "idle flag");
    xfer(1'b1, OFS_IM, 32'h40);
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      remote_u.send(b);
    end
    rdc(OFS_RIS, 32'h40, 32'h0, "early timeout");
    repeat (530) @(posedge clk_in);
    rdc(OFS_MIS, '1, 32'h40, "timeout");
    chk("irq", {31'h0, irq}, 32'h1);
    for (int i = 0; i < 3; i++) rdc(OFS_DATA, '1, {24'h0, exp_q.pop_front()}, "rx");
    rdc(OFS_RIS, 32'h40, 32'h0, "timeout gone");
    xfer(1'b1, OFS_IM, 32'h0);
    remote_u.hold_low(400);
    rdc(OFS_DATA, 32'h4ff, 32'h400, "break");
    rdc(OFS_FLAG, 32'h10, 32'h10, "one break char");
    xfer(1'b1, OFS_CTL, 32'h300);
    xfer(1'b1, OFS_LCR, 32'h60);
    xfer(1'b1, OFS_CTL, 32'h301);
    b = 8'($urandom);
    remote_u.send(b);
    remote_u.send(~b);
    rdc(OFS_RSR, 32'h8, 32'h8, "overrun");
    rdc(OFS_DATA, 32'hff, {24'h0, b}, "held char");
    xfer(1'b1, OFS_CTL, 32'h300);
    // 7 data bits, even parity, two stops; dropped char tags this one
    xfer(1'b1, OFS_LCR, 32'h4e);
    xfer(1'b1, OFS_CTL, 32'h381);
    b = 8'($urandom);
    xfer(1'b1, OFS_DATA, {24'h0, b});
    repeat (250) @(posedge clk_in);
    rdc(OFS_DATA, 32'hfff, {20'h0, 4'h8, 1'b0, b[6:0]}, "loopback");
    tally_and_finish;
  end
endmodule
